// [bench/testbench.sv]
// Self-checking bench for the bulk DMA channel.
// Assumes the far-side model and the bound checker are compiled.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
  `define WAIT(c) begin wk = 0; while (!(c) && wk < 4000) begin @(posedge core_clk); \
    wk++; end if (wk == 4000) begin err_total++; end_of_test(); end end
  localparam logic [17:0] CDR = uubd_pkg::ADDR_RX_CDR, CSR = uubd_pkg::ADDR_RX_CSR;
  localparam logic [17:0] TCDR = uubd_pkg::ADDR_TX_CDR, TCSR = uubd_pkg::ADDR_TX_CSR;
  logic core_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic rx_error = 1'b0, sof = 1'b0, pready, pslverr, perr, rx_valid, rx_ready, rx_irq, tx_irq;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000, prdata, rv;
  logic in_handover_x, in_handover_y, in_buffer_select, inbuf_wr_en, inbuf_wr_sel, in_post;
  logic in_post_sel, out_handover_x, out_handover_y, out_cnt_sel, outbuf_rd_en, outbuf_rd_sel;
  logic out_release, out_release_sel, tx_valid, tx_ready, out_buffer_select;
  logic [5:0] inbuf_wr_addr, outbuf_rd_addr;
  logic [6:0] in_post_count, out_byte_count;
  logic [7:0] rx_data, tx_data, inbuf_wr_data, outbuf_rd_data;
  int err_total = 0, comparisons = 0, wk, rx_irqs = 0, tx_irqs = 0;

  uubd_dma_channel u_dut (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_valid, .rx_data, .rx_ready, .rx_error, .tx_valid,
    .tx_data, .tx_ready, .sof, .in_handover_x, .in_handover_y, .in_buffer_select,
    .inbuf_wr_en, .inbuf_wr_sel, .inbuf_wr_addr, .inbuf_wr_data, .in_post, .in_post_sel,
    .in_post_count, .out_handover_x, .out_handover_y, .out_buffer_select,
    .out_byte_count, .out_cnt_sel, .outbuf_rd_en, .outbuf_rd_sel, .outbuf_rd_addr,
    .outbuf_rd_data, .out_release, .out_release_sel, .rx_irq, .tx_irq);
  uubd_far_model u_far (.core_clk, .rx_ready, .inbuf_wr_en, .inbuf_wr_data, .in_post,
    .in_post_sel, .in_post_count, .out_cnt_sel, .outbuf_rd_en, .outbuf_rd_sel,
    .outbuf_rd_addr, .tx_valid, .tx_data, .out_release, .out_release_sel, .rx_valid, .rx_data,
    .in_handover_x, .in_handover_y, .in_buffer_select, .out_handover_x, .out_handover_y,
    .out_buffer_select, .out_byte_count, .outbuf_rd_data, .tx_ready);

  // 25 MHz core clock
  initial forever #20 core_clk = ~core_clk;
  // Interrupt pulse tallies
  always @(posedge core_clk)
  begin
    rx_irqs <= rx_irqs + (rx_irq === 1'b1);
    tx_irqs <= tx_irqs + (tx_irq === 1'b1);
  end

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    `WAIT(pready === 1'b1)
    rv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic rdc(input logic [17:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK("register", e, rv[7:0])
  endtask : rdc
  // Frame ticks spaced a few cycles apart
  task automatic tick(input int n);
    repeat (n)
    begin
      sof <= 1'b1;
      @(posedge core_clk);
      sof <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask : tick
  task automatic feed(input int n);
    u_far.rx_goal <= u_far.rx_goal + n;
    @(posedge core_clk);
    `WAIT(u_far.rx_sent == u_far.rx_goal)
    repeat (2) @(posedge core_clk);
  endtask : feed

  // Reset values, write-one clear, unmapped word
  task automatic t_regs;
    rdc(CSR, 8'h00);
    rdc(CDR, 8'h08);
    apb(1'b1, CSR, 8'hff);
    rdc(CSR, 8'hfc);
    rdc(18'h00010, 8'h00);
    `CHK("slave error", 1'b1, perr)
  endtask : t_regs
  // Two full buffers, then a short one at time-out
  task automatic t_in;
    apb(1'b1, CSR, 8'h8c);
    apb(1'b1, CDR, 8'ha0);
    feed(128);
    `CHK("posts", 2, u_far.posts)
    `CHK("count", 7'h40, u_far.last_cnt)
    apb(1'b1, CDR, 8'he0);
    feed(5);
    tick(2);
    rdc(CSR, 8'h8c);
    tick(1);
    rdc(CSR, 8'h8e);
    `CHK("short count", 7'h05, u_far.last_cnt)
    `CHK("rx irq", 1, rx_irqs)
    rdc(CDR, 8'h78);
  endtask : t_in
  // Host busy: both buffers full, then time-out with enable kept
  task automatic t_ovr;
    apb(1'b1, CSR, 8'h8e);
    apb(1'b1, CDR, 8'ha0);
    tick(4);
    rdc(CSR, 8'h8c);
    u_far.host_busy <= 1'b1;
    u_far.rx_goal <= u_far.rx_goal + 140;
    `WAIT(u_far.posts == 5)
    tick(3);
    rdc(CSR, 8'h8f);
    apb(1'b0, CDR, 8'h00);
    `CHK("enable kept", 1'b1, rv[7])
    apb(1'b1, CSR, 8'h8d);
    rdc(CSR, 8'h8e);
    apb(1'b1, CSR, 8'h8c);
    rdc(CSR, 8'h8e);
    u_far.host_busy <= 1'b0;
    feed(0);
    apb(1'b1, CSR, 8'h0e);
    feed(2);
    tick(5);
    rdc(CSR, 8'h0c);
  endtask : t_ovr
  // Receiver error halts without interrupt
  task automatic t_err;
    apb(1'b1, CSR, 8'h8c);
    apb(1'b1, CDR, 8'he0);
    feed(3);
    rx_error <= 1'b1;
    @(posedge core_clk);
    rx_error <= 1'b0;
    repeat (3) @(posedge core_clk);
    rdc(CSR, 8'h8e);
    apb(1'b0, CDR, 8'h00);
    `CHK("enable after error", 1'b1, rv[7])
    `CHK("halted", 1'b0, rx_ready)
    `CHK("no irq", 1, rx_irqs)
    // Software stop with interrupts off
    apb(1'b1, CDR, 8'h20);
    apb(1'b0, CDR, 8'h00);
    `CHK("stopped", 1'b0, rv[7])
  endtask : t_err
  // Full X then short Y to the stalling transmitter
  task automatic t_tx;
    u_far.out_len <= '{7'h40, 7'h05};
    u_far.tx_slow <= 1'b1;
    u_far.out_handover_x <= 1'b1;
    u_far.out_handover_y <= 1'b1;
    apb(1'b1, TCDR, 8'he0);
    `WAIT(u_far.rels == 2)
    repeat (4) @(posedge core_clk);
    `CHK("tx bytes", 69, u_far.tx_n)
    `CHK("tx data", 0, u_far.tx_bad + u_far.wr_bad)
    rdc(TCSR, 8'h01);
    `CHK("tx irq", 1, tx_irqs)
    `CHK("released", 1'b0, out_handover_y)
  endtask : t_tx

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // Reset for six cycles, then the scenarios
  initial
  begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_in();
    t_ovr();
    t_err();
    t_tx();
    end_of_test();
  end
endmodule : testbench

// [bench/uubd_chk_props.sv]
// Port checker for the bulk DMA channel.
// Assumes one clock domain; bound onto uubd_dma_channel below.
module uubd_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic in_handover_x,
  input wire logic in_handover_y,
  input wire logic inbuf_wr_en,
  input wire logic inbuf_wr_sel,
  input wire logic [5:0] inbuf_wr_addr,
  input wire logic [7:0] inbuf_wr_data,
  input wire logic in_post,
  input wire logic in_post_sel,
  input wire logic [6:0] in_post_count,
  input wire logic outbuf_rd_en,
  input wire logic outbuf_rd_sel,
  input wire logic out_cnt_sel,
  input wire logic [7:0] outbuf_rd_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic rx_irq
);
  // Everything runs on the core clock, quiet in reset
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  chk_byte_lands: assert property (rx_valid && rx_ready |=>
    inbuf_wr_en && inbuf_wr_data == $past(rx_data)) else $error("byte not written");
  chk_full_post: assert property (in_post && in_post_count == 7'h40 |->
    inbuf_wr_en && inbuf_wr_addr == 6'h3f && in_post_sel == inbuf_wr_sel)
    else $error("full post wrong");
  chk_busy_block: assert property (!in_handover_x && !in_handover_y |-> !rx_ready)
    else $error("accepts with both buffers busy");
  chk_wr_free: assert property (inbuf_wr_en |->
    (inbuf_wr_sel ? $past(in_handover_y) : $past(in_handover_x))) else $error("busy write");
  chk_irq_stop: assert property (rx_irq |-> !rx_ready ##1 !rx_irq)
    else $error("irq while running");
  chk_tx_path: assert property (outbuf_rd_en |-> outbuf_rd_sel == out_cnt_sel ##2
    tx_valid && tx_data == $past(outbuf_rd_data)) else $error("tx byte wrong");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx dropped");
  chk_post_size: assert property (in_post |-> in_post_count inside {[7'h01:7'h40]})
    else $error("post count out of range");
endmodule : uubd_chk

bind uubd_dma_channel uubd_chk u_chk (.core_clk, .srst, .rx_valid, .rx_data, .rx_ready,
  .in_handover_x, .in_handover_y, .inbuf_wr_en, .inbuf_wr_sel, .inbuf_wr_addr, .inbuf_wr_data,
  .in_post, .in_post_sel, .in_post_count, .outbuf_rd_en, .outbuf_rd_sel, .out_cnt_sel,
  .outbuf_rd_data, .tx_valid, .tx_data, .tx_ready, .rx_irq);

// [bench/uubd_far_model.sv]
// Far side: USB buffer manager and serial FIFO ends.
// Assumes the bench steers it through its tally and control variables.
module uubd_far_model (
  input wire logic core_clk,
  input wire logic rx_ready,
  input wire logic inbuf_wr_en,
  input wire logic [7:0] inbuf_wr_data,
  input wire logic in_post,
  input wire logic in_post_sel,
  input wire logic [6:0] in_post_count,
  input wire logic out_cnt_sel,
  input wire logic outbuf_rd_en,
  input wire logic outbuf_rd_sel,
  input wire logic [5:0] outbuf_rd_addr,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic out_release,
  input wire logic out_release_sel,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic in_handover_x,
  output logic in_handover_y,
  output logic in_buffer_select,
  output logic out_handover_x,
  output logic out_handover_y,
  output logic out_buffer_select,
  output logic [6:0] out_byte_count,
  output logic [7:0] outbuf_rd_data,
  output logic tx_ready
);
  int rx_goal = 0, rx_sent = 0, take; // Bytes offered and taken
  int posts = 0, wr_bad = 0, tx_n = 0, tx_bad = 0, rels = 0; // Tallies
  bit host_busy = 1'b0; // Host leaves IN buffers unsent
  bit tx_slow = 1'b0; // Stalls the transmitter
  logic [6:0] last_cnt = 7'h00; // Last posted IN count
  logic [6:0] out_len [2] = '{7'h00, 7'h00}; // OUT count per buffer
  logic [7:0] wr_exp = 8'h00; // Next byte due in an IN buffer
  logic [5:0] tx_idx = 6'h00; // Byte index in the OUT buffer
  logic tx_buf = 1'b0; // OUT buffer being drained
  initial {rx_valid, rx_data, tx_ready, outbuf_rd_data} = 18'h00000;
  initial {in_handover_x, in_handover_y, in_buffer_select} = 3'h6;
  initial {out_handover_x, out_handover_y} = 2'h0;
  // Count of the buffer the channel names
  assign out_byte_count = out_len[out_cnt_sel];
  // Manager's select names the OUT buffer it expects drained next
  assign out_buffer_select = tx_buf;

  // Feeds, buffers and transmitter; idle data never repeats the last value
  always @(posedge core_clk)
  begin
    take = (rx_valid && rx_ready) ? 1 : 0;
    rx_sent <= rx_sent + take;
    rx_valid <= (rx_sent + take) < rx_goal;
    rx_data <= ((rx_sent + take) < rx_goal) ? 8'(rx_sent + take) : ~rx_data;
    wr_bad <= wr_bad + (inbuf_wr_en && inbuf_wr_data !== wr_exp);
    wr_exp <= wr_exp + 8'(inbuf_wr_en);
    // Posted buffer goes to the host, select toggles
    if (in_post)
    begin
      posts <= posts + 1;
      last_cnt <= in_post_count;
      in_buffer_select <= ~in_post_sel;
      if (in_post_sel)
        in_handover_y <= 1'b0;
      else
        in_handover_x <= 1'b0;
    end
    else if (!host_busy)
      {in_handover_x, in_handover_y} <= 2'h3;
    outbuf_rd_data <= outbuf_rd_en ? {outbuf_rd_sel, 1'b0, outbuf_rd_addr} : ~outbuf_rd_data;
    tx_ready <= tx_slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready)
    begin
      tx_n <= tx_n + 1;
      tx_bad <= tx_bad + (tx_data !== {tx_buf, 1'b0, tx_idx});
      tx_idx <= tx_idx + 6'h01;
    end
    // Released OUT buffer returns to the manager
    if (out_release)
    begin
      rels <= rels + 1;
      tx_buf <= ~tx_buf;
      tx_idx <= 6'h00;
      if (out_release_sel)
        out_handover_y <= 1'b0;
      else
        out_handover_x <= 1'b0;
    end
  end
endmodule : uubd_far_model

// [hw/uubd_dma_channel.sv]
// Serial-to-USB bulk DMA channel: receive path into IN buffers, transmit
// path out of OUT buffers, and the channel registers on APB.
// Assumes the buffer manager owns the X/Y memories and handover bits.
//
// The APB interface to the registers was decided locally.

module uubd_dma_channel (
  input wire logic core_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uubd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial receiver FIFO
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  input wire logic rx_error,
  // Serial transmitter
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Frame tick
  input wire logic sof,
  // IN buffers (handover bit 1 = free for the DMA)
  input wire logic in_handover_x,
  input wire logic in_handover_y,
  input wire logic in_buffer_select,
  output logic inbuf_wr_en,
  output logic inbuf_wr_sel,
  output logic [uubd_pkg::PTR_W-1:0] inbuf_wr_addr,
  output logic [7:0] inbuf_wr_data,
  output logic in_post,
  output logic in_post_sel,
  output logic [uubd_pkg::CNT_W-1:0] in_post_count,
  // OUT buffers (handover bit 1 = filled by the manager)
  input wire logic out_handover_x,
  input wire logic out_handover_y,
  input wire logic out_buffer_select,
  input wire logic [uubd_pkg::CNT_W-1:0] out_byte_count,
  output logic out_cnt_sel,
  output logic outbuf_rd_en,
  output logic outbuf_rd_sel,
  output logic [uubd_pkg::PTR_W-1:0] outbuf_rd_addr,
  input wire logic [7:0] outbuf_rd_data,
  output logic out_release,
  output logic out_release_sel,
  // Completion interrupts
  output logic rx_irq,
  output logic tx_irq
);
  // Transmit path states, Gray from IDLE through READ, LATCH and SEND to DONE
  typedef enum logic [2:0] {
    UUBD_O_IDLE = 3'b000,
    UUBD_O_READ = 3'b001,
    UUBD_O_LATCH = 3'b011,
    UUBD_O_SEND = 3'b010,
    UUBD_O_DONE = 3'b110
  } uubd_ostate_t;

  // Register state
  logic rx_en_r; // Receive channel enable
  logic rx_ine_r; // Receive completion interrupt enable
  logic rx_cont_r; // Continuous mode bit
  logic [2:0] rx_ep_r; // Receive descriptor pointer
  logic tx_en_r;
  logic tx_ine_r;
  logic tx_cont_r;
  logic [2:0] tx_ep_r;
  logic ten_r; // Time-out enable
  logic [uubd_pkg::TO_W-1:0] to_val_r; // Time-out in ms
  logic ovr_q; // Overrun flag
  logic tof_q; // Time-out flag
  logic partial_packet_flag_q; // Partial packet flag
  // Receive path state
  logic rx_halt_r; // Stopped by receiver error, enable kept
  logic first_byte_r; // A byte has moved since start
  logic in_sel_r; // Buffer being filled
  logic [uubd_pkg::CNT_W-1:0] in_cnt_r; // Bytes in that buffer
  logic rx_en_d_r; // Enable one cycle ago
  // Transmit path state
  uubd_ostate_t ost_r;
  logic out_sel_r;
  logic [uubd_pkg::CNT_W-1:0] out_len_r;
  logic [uubd_pkg::CNT_W-1:0] out_idx_r;
  logic tx_en_d_r;
  // Decode
  logic wr_acc, rd_setup;
  logic hit_rx_cdr, hit_rx_csr, hit_tx_cdr, hit_tx_csr, hit_any;
  logic rx_take, cur_free, both_full, to_expire;
  logic set_ovr, set_tof, rx_end, tx_end, set_partial_packet_flag;
  logic [7:0] rd_mux;

  assign hit_rx_cdr = (paddr == uubd_pkg::ADDR_RX_CDR);
  assign hit_rx_csr = (paddr == uubd_pkg::ADDR_RX_CSR);
  assign hit_tx_cdr = (paddr == uubd_pkg::ADDR_TX_CDR);
  assign hit_tx_csr = (paddr == uubd_pkg::ADDR_TX_CSR);
  assign hit_any = hit_rx_cdr | hit_rx_csr | hit_tx_cdr | hit_tx_csr;
  // Writes land only in the access phase
  assign wr_acc = psel & penable & pwrite & hit_any;
  assign rd_setup = psel & ~penable & ~pwrite;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // Read mux; the T/R bit always reads as one
  always_comb
  begin
    rd_mux = 8'h00;
    if (hit_rx_cdr)
      rd_mux = {rx_en_r, rx_ine_r, rx_cont_r, in_buffer_select, 1'b1, rx_ep_r};
    else if (hit_rx_csr)
      rd_mux = {ten_r, to_val_r, tof_q, ovr_q};
    else if (hit_tx_cdr)
      rd_mux = {tx_en_r, tx_ine_r, tx_cont_r, out_buffer_select, 1'b1, tx_ep_r};
    else if (hit_tx_csr)
      rd_mux = {7'h00, partial_packet_flag_q};
  end

  // Read data captured in the setup cycle, stable through access
  always_ff @(posedge core_clk)
  begin
    if (srst)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= {24'h00_0000, rd_mux};
  end

  // Static channel settings written by software
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rx_ine_r <= 1'b0;
      rx_cont_r <= 1'b0;
      rx_ep_r <= uubd_pkg::EP_RESET;
      tx_ine_r <= 1'b0;
      tx_cont_r <= 1'b0;
      tx_ep_r <= uubd_pkg::EP_RESET;
      ten_r <= 1'b0;
      to_val_r <= uubd_pkg::TO_RESET;
    end
    else if (wr_acc)
    begin
      if (hit_rx_cdr)
      begin
        rx_ine_r <= pwdata[uubd_pkg::CDR_INE];
        rx_cont_r <= pwdata[uubd_pkg::CDR_CNT];
        rx_ep_r <= pwdata[uubd_pkg::CDR_EP_HI:uubd_pkg::CDR_EP_LO];
      end
      if (hit_tx_cdr)
      begin
        tx_ine_r <= pwdata[uubd_pkg::CDR_INE];
        tx_cont_r <= pwdata[uubd_pkg::CDR_CNT];
        tx_ep_r <= pwdata[uubd_pkg::CDR_EP_HI:uubd_pkg::CDR_EP_LO];
      end
      if (hit_rx_csr)
      begin
        ten_r <= pwdata[uubd_pkg::CSR_TEN];
        to_val_r <= pwdata[uubd_pkg::CSR_TO_HI:uubd_pkg::CSR_TO_LO];
      end
    end
  end

  // Sticky completion flags, cleared by writing one
  uubd_w1c_flag u_ovr (
    .core_clk(core_clk),
    .srst(srst),
    .set(set_ovr),
    .clr(wr_acc & hit_rx_csr & pwdata[uubd_pkg::CSR_OVR]),
    .q(ovr_q)
  );
  uubd_w1c_flag u_tof (
    .core_clk(core_clk),
    .srst(srst),
    .set(set_tof),
    .clr(wr_acc & hit_rx_csr & pwdata[uubd_pkg::CSR_TOF]),
    .q(tof_q)
  );
  uubd_w1c_flag u_partial_packet_flag (
    .core_clk(core_clk),
    .srst(srst),
    .set(set_partial_packet_flag),
    .clr(wr_acc & hit_tx_csr & pwdata[uubd_pkg::CSR_PARTIAL_PACKET_FLAG]),
    .q(partial_packet_flag_q)
  );

  // Receive side: the current buffer is free while its handover bit is 1
  assign cur_free = in_sel_r ? in_handover_y : in_handover_x;
  assign both_full = ~in_handover_x & ~in_handover_y;
  // No writes when halted or when the buffer is still owned by the host
  // Refused while a stop or restart is applied, so no taken byte is lost
  assign rx_ready = rx_en_r & ~rx_halt_r & cur_free & ~to_expire & ~rx_error &
    ~(wr_acc & hit_rx_cdr);
  assign rx_take = rx_valid & rx_ready;

  // Counter runs only with time-out, channel and first byte all on
  uubd_timeout_ctr #(
    .W(uubd_pkg::TO_W)
  ) u_to (
    .core_clk(core_clk),
    .srst(srst),
    .run(ten_r & rx_en_r & ~rx_halt_r & first_byte_r),
    .reload(rx_take),
    .sof(sof),
    .load_val(to_val_r),
    .expire(to_expire)
  );

  // Completion code: every time-out sets the time-out flag, and both full adds overrun
  assign set_ovr = to_expire & both_full;
  // Prose code for receiver errors: time-out flag set, overrun clear
  assign set_tof = to_expire | (rx_error & rx_en_r & ~rx_halt_r);
  // Only a time-out ends the channel, and only with interrupts on
  assign rx_end = to_expire & rx_ine_r;

  // Receive enable: software starts, a time-out with interrupts on ends
  always_ff @(posedge core_clk)
  begin
    if (srst)
      rx_en_r <= 1'b0;
    else if (rx_end)
      rx_en_r <= 1'b0;
    else if (wr_acc && hit_rx_cdr)
      rx_en_r <= pwdata[uubd_pkg::CDR_EN];
  end

  // Fill the current buffer, post it at 64 or on a time-out or receiver error
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rx_halt_r <= 1'b0;
      first_byte_r <= 1'b0;
      in_sel_r <= 1'b0;
      in_cnt_r <= '0;
      in_post <= 1'b0;
      in_post_sel <= 1'b0;
      in_post_count <= '0;
      inbuf_wr_en <= 1'b0;
      inbuf_wr_sel <= 1'b0;
      inbuf_wr_addr <= '0;
      inbuf_wr_data <= 8'h00;
    end
    else
    begin
      in_post <= 1'b0;
      inbuf_wr_en <= 1'b0;
      if (wr_acc && hit_rx_cdr && pwdata[uubd_pkg::CDR_EN])
      begin
        // Fresh start takes the select bit as the first buffer
        rx_halt_r <= 1'b0;
        first_byte_r <= 1'b0;
        in_cnt_r <= '0;
        in_sel_r <= in_buffer_select;
      end
      else if (to_expire || (rx_error && rx_en_r && !rx_halt_r))
      begin
        // Hand over what was gathered; an empty buffer is kept
        if (in_cnt_r != '0 && cur_free)
        begin
          in_post <= 1'b1;
          in_post_sel <= in_sel_r;
          in_post_count <= in_cnt_r;
          in_sel_r <= ~in_sel_r;
        end
        in_cnt_r <= '0;
        first_byte_r <= 1'b0;
        rx_halt_r <= ~to_expire;
      end
      else if (rx_take)
      begin
        first_byte_r <= 1'b1;
        inbuf_wr_en <= 1'b1;
        inbuf_wr_sel <= in_sel_r;
        inbuf_wr_addr <= in_cnt_r[uubd_pkg::PTR_W-1:0];
        inbuf_wr_data <= rx_data;
        if (in_cnt_r == uubd_pkg::CNT_W'(uubd_pkg::BUF_BYTES - 1))
        begin
          // Full packet: post and move to the other buffer
          in_post <= 1'b1;
          in_post_sel <= in_sel_r;
          in_post_count <= uubd_pkg::CNT_W'(uubd_pkg::BUF_BYTES);
          in_sel_r <= ~in_sel_r;
          in_cnt_r <= '0;
        end
        else
          in_cnt_r <= in_cnt_r + uubd_pkg::CNT_W'(1);
      end
    end
  end

  // Transmit side: a short packet sets the flag, and ends the channel only with interrupts on
  assign set_partial_packet_flag = (ost_r == UUBD_O_DONE) &&
    (out_len_r < uubd_pkg::CNT_W'(uubd_pkg::BUF_BYTES));
  assign tx_end = set_partial_packet_flag & tx_ine_r;

  // Transmit enable
  always_ff @(posedge core_clk)
  begin
    if (srst)
      tx_en_r <= 1'b0;
    else if (tx_end)
      tx_en_r <= 1'b0;
    else if (wr_acc && hit_tx_cdr)
      tx_en_r <= pwdata[uubd_pkg::CDR_EN];
  end

  // Byte count read port follows the buffer being examined
  assign out_cnt_sel = out_sel_r;
  assign outbuf_rd_sel = out_sel_r;
  assign outbuf_rd_addr = out_idx_r[uubd_pkg::PTR_W-1:0];
  assign outbuf_rd_en = (ost_r == UUBD_O_READ);
  assign tx_valid = (ost_r == UUBD_O_SEND);

  // Buffer drain: read, latch, send, repeat, then release
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ost_r <= UUBD_O_IDLE;
      out_sel_r <= 1'b0;
      out_len_r <= '0;
      out_idx_r <= '0;
      tx_data <= 8'h00;
      out_release <= 1'b0;
      out_release_sel <= 1'b0;
    end
    else
    begin
      out_release <= 1'b0;
      if (wr_acc && hit_tx_cdr && pwdata[uubd_pkg::CDR_EN] && !tx_en_r)
      begin
        out_sel_r <= out_buffer_select;
        ost_r <= UUBD_O_IDLE;
      end
      else if (!tx_en_r)
        ost_r <= UUBD_O_IDLE; // Stopped by software mid-packet
      else
      begin
        unique case (ost_r)
          UUBD_O_IDLE:
          begin
            // Wait for the manager to hand the buffer over
            if (out_sel_r ? out_handover_y : out_handover_x)
            begin
              out_len_r <= out_byte_count;
              out_idx_r <= '0;
              ost_r <= (out_byte_count == '0) ? UUBD_O_DONE : UUBD_O_READ;
            end
          end
          UUBD_O_READ:
            ost_r <= UUBD_O_LATCH;
          UUBD_O_LATCH:
          begin
            // Memory data is registered, valid one cycle after the read
            tx_data <= outbuf_rd_data;
            ost_r <= UUBD_O_SEND;
          end
          UUBD_O_SEND:
          begin
            if (tx_ready)
            begin
              out_idx_r <= out_idx_r + uubd_pkg::CNT_W'(1);
              ost_r <= (out_idx_r + uubd_pkg::CNT_W'(1) == out_len_r) ?
                UUBD_O_DONE : UUBD_O_READ;
            end
          end
          UUBD_O_DONE:
          begin
            // Give the buffer back and swap to the other one
            out_release <= 1'b1;
            out_release_sel <= out_sel_r;
            out_sel_r <= ~out_sel_r;
            ost_r <= UUBD_O_IDLE;
          end
          default:
            ost_r <= UUBD_O_IDLE;
        endcase
      end
    end
  end

  // Interrupt pulses on the enable falling with interrupts on
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rx_en_d_r <= 1'b0;
      tx_en_d_r <= 1'b0;
      rx_irq <= 1'b0;
      tx_irq <= 1'b0;
    end
    else
    begin
      rx_en_d_r <= rx_en_r;
      tx_en_d_r <= tx_en_r;
      rx_irq <= rx_en_d_r & ~rx_en_r & rx_ine_r;
      tx_irq <= tx_en_d_r & ~tx_en_r & tx_ine_r;
    end
  end
endmodule : uubd_dma_channel

// [hw/uubd_pkg.sv]
// Shared constants for the serial/USB bulk DMA channel.
// Assumes a 32-bit APB slave port and 64-byte X/Y endpoint buffers.
package uubd_pkg;
  // Register indices as printed; the byte address is four times the index
  localparam logic [15:0] IDX_RX_CDR = 16'hffe4;
  localparam logic [15:0] IDX_RX_CSR = 16'hffe5;
  localparam logic [15:0] IDX_TX_CDR = 16'hffe0;
  localparam logic [15:0] IDX_TX_CSR = 16'hffe1;
  localparam int ADDR_W = 18;
  localparam logic [ADDR_W-1:0] ADDR_RX_CDR = {IDX_RX_CDR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RX_CSR = {IDX_RX_CSR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TX_CDR = {IDX_TX_CDR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TX_CSR = {IDX_TX_CSR, 2'b00};
  // Channel definition fields
  localparam int CDR_EP_LO = 0;
  localparam int CDR_EP_HI = 2;
  localparam int CDR_TR = 3;
  localparam int CDR_XY = 4;
  localparam int CDR_CNT = 5;
  localparam int CDR_INE = 6;
  localparam int CDR_EN = 7;
  // Status / time-out fields
  localparam int CSR_OVR = 0;
  localparam int CSR_TOF = 1;
  localparam int CSR_TO_LO = 2;
  localparam int CSR_TO_HI = 6;
  localparam int CSR_TEN = 7;
  localparam int CSR_PARTIAL_PACKET_FLAG = 0;
  // Sizes and reset values
  localparam int TO_W = 5;
  localparam int BUF_BYTES = 64;
  localparam int CNT_W = 7;
  localparam int PTR_W = 6;
  localparam logic [TO_W-1:0] TO_RESET = 5'h00;
  localparam logic [2:0] EP_RESET = 3'h0;
endpackage : uubd_pkg

// [hw/uubd_timeout_ctr.sv]
// Transaction time-out down counter, stepped by start-of-frame pulses.
// Assumes sof is a one-cycle pulse once per millisecond.
module uubd_timeout_ctr #(
  parameter int W = 5
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic run, // Counting allowed
  input wire logic reload, // Byte moved: restart the count
  input wire logic sof, // Frame tick
  input wire logic [W-1:0] load_val, // Time-out in ms
  output logic expire // One-cycle pulse at zero
);
  logic [W-1:0] cnt_r; // Remaining ms
  logic armed_r; // Counter holds a live value

  // Reload on each byte, step on each frame tick
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cnt_r <= '0;
      armed_r <= 1'b0;
      expire <= 1'b0;
    end
    else
    begin
      expire <= 1'b0;
      if (!run)
        armed_r <= 1'b0;
      else if (reload)
      begin
        cnt_r <= load_val;
        armed_r <= 1'b1;
      end
      else if (armed_r && sof)
      begin
        // A zero setting expires on the first tick
        if (cnt_r <= W'(1))
        begin
          cnt_r <= '0;
          armed_r <= 1'b0;
          expire <= 1'b1;
        end
        else
          cnt_r <= cnt_r - W'(1);
      end
    end
  end
endmodule : uubd_timeout_ctr

// [hw/uubd_w1c_flag.sv]
// One sticky status flag: hardware sets it, software clears it by writing 1.
// Assumes set and clear are single-cycle strobes on core_clk.
module uubd_w1c_flag (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic set, // Hardware event
  input wire logic clr, // Write of 1 by software
  output logic q
);
  // Set beats clear so an event in the clear cycle is kept
  always_ff @(posedge core_clk)
  begin
    if (srst)
      q <= 1'b0;
    else if (set)
      q <= 1'b1;
    else if (clr)
      q <= 1'b0;
  end
endmodule : uubd_w1c_flag
